/* File: dv/test_uart_irq_enable_and_status.sv */
`timescale 1ns/1ns
module test_uart_irq_enable_and_status;
  logic        clock, resetn, cs_n, rd_n, wr_n, data_oe_n, irq, rx_push, rx_overrun;
  logic        rx_head_parity, rx_head_framing, rx_head_break, rx_any_error;
  logic        tx_shift_empty, modem_evt, sleep_enable, fifo_enable, ovr, dr;
  logic [2:0]  addr;
  logic [7:0]  data_in, data_out, rx_data, modem_status, thr_data, rx_fill, tx_fill;
  logic [7:0]  rx_trigger, tx_trigger, x, modem_control, enhanced_function, feature_control;
  logic        rhr_read, rx_fifo_clr, tx_fifo_clr;
  logic [31:0] seed;
  int          n_fail, num_checks;
  int          n_pulse = 0;

  uie_top #(.FILL_W(8)) dut (.clock(clock), .resetn(resetn), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .irq(irq), .rx_data(rx_data), .rx_fill(rx_fill),
    .rx_push(rx_push), .rx_overrun(rx_overrun), .rx_head_parity(rx_head_parity),
    .rx_head_framing(rx_head_framing), .rx_head_break(rx_head_break),
    .rx_any_error(rx_any_error), .tx_fill(tx_fill), .tx_shift_empty(tx_shift_empty),
    .modem_status(modem_status), .modem_evt(modem_evt), .rhr_read(rhr_read), .thr_write(),
    .thr_data(thr_data), .rx_fifo_clr(rx_fifo_clr), .tx_fifo_clr(tx_fifo_clr),
    .fifo_enable(fifo_enable), .sleep_enable(sleep_enable), .modem_control(modem_control),
    .enhanced_function(enhanced_function), .feature_control(feature_control),
    .rx_trigger(rx_trigger), .tx_trigger(tx_trigger));

  // Side-effect strobes last one cycle, so they are counted rather than sampled.
  always @(posedge clock) begin
    if (resetn === 1'b1) begin
      n_pulse <= n_pulse + rhr_read + rx_fifo_clr + tx_fifo_clr;
    end
  end

  uie_host host (.clock(clock), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));

  // Free-running 4 ns clock.
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Fixed-seed xorshift keeps every run identical.
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  // Expected line status from the driven datapath levels and the bench flags.
  function automatic logic [7:0] lsr_exp();
    return {rx_any_error, (tx_fill == 8'h00) & tx_shift_empty, tx_fill == 8'h00,
            rx_head_break, rx_head_framing, rx_head_parity, ovr, dr};
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       o;
    host.acc(1'b1, a, d, q, o);
  endtask

  // A read must also turn the data bus around.
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic       o;
    host.acc(1'b0, a, 8'h00, q, o);
    chk1(o, 1'b0);
    chk8(q, e);
  endtask

  // The output is registered, so allow a short bounded settling time.
  task automatic wait_irq(input logic e);
    int n;
    n = 0;
    while (irq !== e && n < 8) begin
      @(posedge clock);
      n++;
    end
    chk1(irq, e);
  endtask

  // New receive fill; a rise comes with a push, and an overrun pulse may ride along.
  task automatic fill(input logic [7:0] f, input logic ov);
    @(posedge clock);
    rx_push <= (f > rx_fill);
    rx_fill <= f;
    rx_overrun <= ov;
    @(posedge clock);
    rx_push <= 1'b0;
    rx_overrun <= 1'b0;
    ovr = ovr | ov;
    dr = (f != 8'h00);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  // A hang is cut short here.
  initial begin
    repeat (30000) @(posedge clock);
    n_fail++;
    end_sim();
  end

  initial begin
    {resetn, rx_push, rx_overrun, rx_head_parity, rx_head_framing} = 5'h00;
    {rx_head_break, rx_any_error, tx_shift_empty, modem_evt} = 4'h0;
    {rx_data, rx_fill, tx_fill, modem_status} = 32'h00000500;
    {ovr, dr, n_fail, num_checks} = 0;
    seed = 32'h000012F2;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    rd(3'h1, 8'h00);
    rd(3'h2, 8'h01);
    chk1(data_oe_n, 1'b1);
    chk1(irq, 1'b0);
    wr(3'h1, 8'hFF);
    rd(3'h1, 8'h0F);
    wr(3'h3, 8'hBF);
    wr(3'h2, 8'h10);
    wr(3'h0, 8'h04);
    wr(3'h1, 8'h80);
    wr(3'h0, 8'h04);
    rd(3'h1, 8'h80);
    chk8(enhanced_function, 8'h10);
    chk8(feature_control, 8'h80);
    wr(3'h3, 8'h03);
    wr(3'h4, 8'hE5);
    chk8(modem_control, 8'hE5);
    wr(3'h1, 8'hF0);
    rd(3'h1, 8'hF0);
    chk1(sleep_enable, 1'b1);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h07);
    rd(3'h0, 8'h00);
    chk8(n_pulse[7:0], 8'h03);
    chk8(rx_trigger, 8'h04);
    chk8(tx_trigger, 8'h04);
    chk1(fifo_enable, 1'b1);
    done("registers");
    // Polled mode: all sources masked while the status flags are read directly.
    for (int i = 0; i < 4; i++) begin
      x = rnd();
      @(posedge clock);
      {rx_any_error, rx_head_break, rx_head_framing, rx_head_parity} <= x[3:0];
      tx_fill <= {6'h00, x[5:4]};
      tx_shift_empty <= x[6];
      rx_data <= rnd();
      modem_status <= rnd();
      fill({5'h00, x[2:0]} + 8'h01, x[7]);
      rd(3'h5, lsr_exp());
      ovr = 1'b0;
      rd(3'h6, modem_status);
      rd(3'h2, 8'hC1);
      chk1(irq, 1'b0);
    end
    @(posedge clock);
    {rx_any_error, rx_head_break, rx_head_framing, rx_head_parity} <= 4'h0;
    tx_fill <= 8'h05;
    fill(8'h00, 1'b0);
    rd(3'h5, lsr_exp());
    done("polled");
    // Receive level against trigger 4, with the enable on and then off.
    for (int i = 0; i < 4; i++) begin
      wr(3'h1, {7'h00, i != 3});
      fill((i % 2 == 1) ? 8'h04 : 8'h03, 1'b0);
      wait_irq(i == 1);
      rd(3'h2, (i == 1) ? 8'hC4 : 8'hC1);
    end
    done("receive");
    wr(3'h1, 8'h04);
    fill(8'h03, 1'b1);
    wait_irq(1'b1);
    rd(3'h2, 8'hC6);
    rd(3'h5, lsr_exp());
    ovr = 1'b0;
    wait_irq(1'b0);
    rd(3'h2, 8'hC1);
    done("line");
    // Enabling while already empty fires at once; a later emptying fires again.
    @(posedge clock);
    tx_fill <= 8'h00;
    wr(3'h1, 8'h02);
    wait_irq(1'b1);
    rd(3'h2, 8'hC2);
    wait_irq(1'b0);
    @(posedge clock);
    tx_fill <= 8'h05;
    repeat (4) @(posedge clock);
    tx_fill <= 8'h00;
    wait_irq(1'b1);
    x = rnd();
    wr(3'h0, x);
    chk8(thr_data, x);
    wait_irq(1'b0);
    done("transmit");
    @(posedge clock);
    modem_evt <= 1'b1;
    wait_irq(1'b0);
    wr(3'h1, 8'h08);
    wait_irq(1'b1);
    rd(3'h2, 8'hC0);
    @(posedge clock);
    modem_evt <= 1'b0;
    wait_irq(1'b0);
    rd(3'h2, 8'hC1);
    done("modem");
    end_sim();
  end
endmodule // test_uart_irq_enable_and_status

/* File: dv/uie_host.sv */
`timescale 1ns/1ns
module uie_host (
  // Clock.
  input  wire logic       clock,
  // Host register port pins.
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic [2:0]      addr,
  output logic [7:0]      data_in,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe_n
);
  // Idle pins at time zero.
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 3'h0;
    data_in = 8'hA5;
  end

  // One strobe; address and data settle an edge ahead and hold until release.
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic oe_n);
    @(posedge clock);
    addr <= a;
    data_in <= d;
    @(posedge clock);
    cs_n <= 1'b0;
    rd_n <= w;
    wr_n <= ~w;
    repeat (6) @(posedge clock);
    q = data_out;
    oe_n = data_oe_n;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    data_in <= ~d; // Released lines must not keep a stale value.
    repeat (4) @(posedge clock);
  endtask
endmodule // uie_host

/* File: logic/uie_defs.svh */
`ifndef UIE_DEFS_SVH
`define UIE_DEFS_SVH
// Register offsets on the three-bit address port.
`define UIE_OFS_DATA      3'h0
`define UIE_OFS_IER       3'h1
`define UIE_OFS_ISR_FCR   3'h2
`define UIE_OFS_LCR       3'h3
`define UIE_OFS_MCR       3'h4
`define UIE_OFS_LSR       3'h5
`define UIE_OFS_MSR       3'h6
`define UIE_OFS_SCRATCH   3'h7
`define UIE_OFS_TRG       3'h0
`define UIE_OFS_FEATURE_CONTROL      3'h1
`define UIE_OFS_EFR       3'h2
`define UIE_OFS_CHAR_BASE 3'h4
// Line control value that opens the enhanced map.
`define UIE_LCR_ENHANCED  8'hBF
// Field positions.
`define UIE_LCR_DLAB      7
`define UIE_EFR_ENH       4
`define UIE_FCR_FIFO_EN   0
`define UIE_FCR_RX_RST    1
`define UIE_FCR_TX_RST    2
`define UIE_FEATURE_CONTROL_TX_SEL   7
// Masks of the extended bits that need the enhanced enable.
`define UIE_IER_EXT_MASK  8'hF0
`define UIE_FCR_EXT_MASK  8'h30
`define UIE_MCR_EXT_MASK  8'hE0
// Reset values.
`define UIE_RST_BYTE      8'h00
`define UIE_RST_TRIG      8'h01
`endif

/* File: logic/uie_irq.sv */
`timescale 1ns/1ns
module uie_irq (
  // Clock and reset.
  input  wire logic clock,
  input  wire logic resetn,
  // Link to the register file.
  uie_irq_if.eval   bus
);
  logic                   tx_cond_reg, tx_cond_next;
  logic                   ier1_reg, ier1_next;
  logic                   tx_flag_reg, tx_flag_next;
  logic                   irq_reg, irq_next;
  uie_pkg::uie_isr_code_t code_reg, code_next;
  logic                   rx_src, tx_src, ls_src, ms_src, tx_cond;

  // Gate each source with its enable and pick the highest pending one.
  always_comb begin
    tx_cond = bus.fifo_en ? (bus.tx_fill < bus.tx_trig) : (bus.tx_fill == '0); // R11
    rx_src = bus.ier_low[0] & (bus.fifo_en ? (bus.rx_fill >= bus.rx_trig)
                                           : (bus.rx_fill != '0)); // R2 R10
    ls_src = bus.ier_low[2] & bus.line_err; // R13
    ms_src = bus.ier_low[3] & bus.modem_evt; // R14
    tx_src = bus.ier_low[1] & tx_flag_reg; // R1
    tx_cond_next = tx_cond;
    ier1_next = bus.ier_low[1];
    tx_flag_next = tx_flag_reg;
    // A fresh empty event wins over a clear in the same cycle.
    if ((tx_cond & ~tx_cond_reg) | (bus.ier_low[1] & ~ier1_reg & tx_cond)) begin // R12
      tx_flag_next = 1'b1;
    end else if ((bus.isr_read & (code_reg == uie_pkg::UIE_ISR_TXRDY)) | bus.thr_write) begin
      tx_flag_next = 1'b0;
    end
    if (ls_src) begin
      code_next = uie_pkg::UIE_ISR_LINE;
    end else if (rx_src) begin
      code_next = uie_pkg::UIE_ISR_RXRDY; // R3
    end else if (tx_src) begin
      code_next = uie_pkg::UIE_ISR_TXRDY;
    end else if (ms_src) begin
      code_next = uie_pkg::UIE_ISR_MODEM;
    end else begin
      code_next = uie_pkg::UIE_ISR_NONE; // R17
    end
    irq_next = ls_src | rx_src | tx_src | ms_src; // R18
  end

  // State registers; the empty condition starts as seen so reset does not fire it.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      tx_cond_reg <= 1'b1;
      ier1_reg    <= 1'b0;
      tx_flag_reg <= 1'b0;
      irq_reg     <= 1'b0;
      code_reg    <= uie_pkg::UIE_ISR_NONE;
    end else begin
      tx_cond_reg <= tx_cond_next;
      ier1_reg    <= ier1_next;
      tx_flag_reg <= tx_flag_next;
      irq_reg     <= irq_next;
      code_reg    <= code_next;
    end
  end

  assign bus.code = code_reg;
  assign bus.irq  = irq_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_tx_arm;
    bus.ier_low[1] && !ier1_reg && tx_cond;
  endsequence
  sequence s_no_clear;
    !bus.thr_write && !bus.isr_read;
  endsequence

  AST_RX_RAISE: assert property (rx_src |=> irq_reg) // R2
    else $error("Receive level reached without interrupt.");
  AST_RX_CODE: assert property (rx_src && !ls_src |=> code_reg == uie_pkg::UIE_ISR_RXRDY) // R3
    else $error("Receive level not shown in status code.");
  AST_RX_DROP: assert property (bus.fifo_en && bus.rx_fill < bus.rx_trig && !ls_src
    && !tx_src && !ms_src |=> !irq_reg) // R2
    else $error("Interrupt held below receive trigger.");
  AST_TX_ARM: assert property (s_tx_arm ##1 s_no_clear |=> tx_flag_reg && irq_reg) // R12
    else $error("Enabling transmit interrupt while empty did not fire.");
  AST_LINE: assert property (ls_src |=> code_reg == uie_pkg::UIE_ISR_LINE && irq_reg) // R13
    else $error("Line error not reported first.");
  AST_MODEM_OFF: assert property (!bus.ier_low[3] && !bus.ier_low[2] && !bus.ier_low[1]
    && !bus.ier_low[0] |=> !irq_reg) // R14
    else $error("Interrupt raised with all enables clear.");
  AST_IDLE: assert property (!irq_next |=> code_reg == uie_pkg::UIE_ISR_NONE) // R17
    else $error("Status code not idle with nothing pending.");
  AST_PAIR: assert property (irq_reg == (code_reg != uie_pkg::UIE_ISR_NONE)) // R18
    else $error("Interrupt output disagrees with status code.");
endmodule // uie_irq

/* File: logic/uie_irq_if.sv */
`timescale 1ns/1ns
interface uie_irq_if #(parameter int FILL_W = 8);
  logic                  fifo_en;
  logic [3:0]            ier_low;
  logic [FILL_W-1:0]     rx_fill;
  logic [FILL_W-1:0]     rx_trig;
  logic [FILL_W-1:0]     tx_fill;
  logic [FILL_W-1:0]     tx_trig;
  logic                  line_err;
  logic                  modem_evt;
  logic                  isr_read;
  logic                  thr_write;
  uie_pkg::uie_isr_code_t code;
  logic                  irq;
  modport regs (output fifo_en, ier_low, rx_fill, rx_trig, tx_fill, tx_trig, line_err,
                output modem_evt, isr_read, thr_write, input code, irq);
  modport eval (input fifo_en, ier_low, rx_fill, rx_trig, tx_fill, tx_trig, line_err,
                input modem_evt, isr_read, thr_write, output code, irq);
endinterface

/* File: logic/uie_pkg.sv */
package uie_pkg;
  // Interrupt source codes shown in the low nibble of the status register.
  typedef enum logic [3:0] {
    UIE_ISR_LINE = 4'h6,
    UIE_ISR_RXRDY = 4'h4,
    UIE_ISR_TXRDY = 4'h2,
    UIE_ISR_MODEM = 4'h0,
    UIE_ISR_NONE = 4'h1
  } uie_isr_code_t;
endpackage

/* File: logic/uie_top.sv */
// Summary of operation
// R1: Interrupt enable gates sources into status register.
// R2: Receive interrupt follows fill against trigger level.
// R3: Status code shows receive level, clears below.
// R4: Data ready sets on push, clears when empty.
// R5: Host polls with FIFOs on, enables low.
// R6: Overrun flag sets on receive overrun.
// R7: Parity, framing, break flags follow head character.
// R8: Holding-empty and all-empty transmit flags reported.
// R9: Top flag shows error anywhere in FIFO.
// R10: Bit 0 enables receive data interrupt.
// R11: Bit 1 enables transmit ready interrupt.
// R12: Enabling transmit interrupt while empty fires it.
// R13: Line errors interrupt when enabled, immediately.
// R14: Bit 3 enables modem status interrupt.
// R15: Sleep enable writable only with enhanced enable.
// R16: Extended bits accessible only with enhanced enable.
// R17: Status bit 0 reads one when idle.
// R18: Interrupt output follows any enabled pending source.
`timescale 1ns/1ns
`include "uie_defs.svh"
module uie_top #(
  parameter int         FILL_W   = 8,
  parameter logic [7:0] REV_CODE = 8'h01, // Arbitrary value.
  parameter logic [7:0] DEV_CODE = 8'h5A  // Arbitrary value.
) (
  // Clock and reset.
  input  wire logic              clock,
  input  wire logic              resetn,
  // Host register port pins.
  input  wire logic              cs_n,
  input  wire logic              rd_n,
  input  wire logic              wr_n,
  input  wire logic [2:0]        addr,
  input  wire logic [7:0]        data_in,
  output logic      [7:0]        data_out,
  output logic                   data_oe_n,
  output logic                   irq,
  // Receive datapath status.
  input  wire logic [7:0]        rx_data,
  input  wire logic [FILL_W-1:0] rx_fill,
  input  wire logic              rx_push,
  input  wire logic              rx_overrun,
  input  wire logic              rx_head_parity,
  input  wire logic              rx_head_framing,
  input  wire logic              rx_head_break,
  input  wire logic              rx_any_error,
  // Transmit datapath status.
  input  wire logic [FILL_W-1:0] tx_fill,
  input  wire logic              tx_shift_empty,
  // Modem status from the modem block.
  input  wire logic [7:0]        modem_status,
  input  wire logic              modem_evt,
  // Controls to the datapath.
  output logic                   rhr_read,
  output logic                   thr_write,
  output logic      [7:0]        thr_data,
  output logic                   rx_fifo_clr,
  output logic                   tx_fifo_clr,
  output logic                   fifo_enable,
  output logic                   sleep_enable,
  output logic      [7:0]        modem_control,
  output logic      [7:0]        enhanced_function,
  output logic      [7:0]        feature_control,
  output logic      [FILL_W-1:0] rx_trigger,
  output logic      [FILL_W-1:0] tx_trigger
);
  if (FILL_W < 8 || FILL_W > 16) begin : g_chk
    $error("FILL_W must lie between 8 and 16.");
  end

  // Pin synchronisers: the first stage feeds only the second.
  logic [2:0]  st1_reg, st2_reg, st3_reg;
  logic [10:0] pin1_reg, pin2_reg;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      st1_reg  <= 3'h7;
      st2_reg  <= 3'h7;
      st3_reg  <= 3'h7;
      pin1_reg <= 11'h000;
      pin2_reg <= 11'h000;
    end else begin
      st1_reg  <= {cs_n, rd_n, wr_n};
      st2_reg  <= st1_reg;
      st3_reg  <= st2_reg;
      pin1_reg <= {addr, data_in};
      pin2_reg <= pin1_reg;
    end
  end

  logic       rd_evt, wr_evt;
  logic [2:0] a;
  logic [7:0] wd;
  // A strobe counts once, at its falling edge with chip select low.
  assign rd_evt = !st2_reg[2] && !st2_reg[1] && st3_reg[1];
  assign wr_evt = !st2_reg[2] && !st2_reg[0] && st3_reg[0];
  assign a  = pin2_reg[10:8];
  assign wd = pin2_reg[7:0];

  // Register state.
  logic [7:0]        ier_reg, ier_next, fcr_reg, fcr_next, lcr_reg, lcr_next;
  logic [7:0]        mcr_reg, mcr_next, efr_reg, efr_next, feature_control_reg, feature_control_next;
  logic [7:0]        scr_reg, scr_next, rdata_reg, rdata_next, thr_reg, thr_next;
  logic [7:0]        chars_reg [4];
  logic [7:0]        chars_next [4];
  logic [FILL_W-1:0] rxt_reg, rxt_next, txt_reg, txt_next;
  logic              dr_reg, dr_next, oe_reg, oe_next, oen_reg, oen_next;
  logic              rhr_rd_reg, rhr_rd_next, thr_wr_reg, thr_wr_next;
  logic              isr_rd_reg, isr_rd_next, lsr_rd_reg, lsr_rd_next;
  logic              rxc_reg, rxc_next, txc_reg, txc_next;
  logic              enh_map, dlab, ext_ok;
  logic [7:0]        line_status, isr_val;

  uie_irq_if #(.FILL_W(FILL_W)) ibus ();

  // Line status word built from live datapath flags and sticky bits.
  always_comb begin
    line_status = {rx_any_error, // R9
                   (tx_fill == '0) & tx_shift_empty, (tx_fill == '0), // R8
                   rx_head_break, rx_head_framing, rx_head_parity, // R7
                   oe_reg, dr_reg};
    isr_val = {fcr_reg[`UIE_FCR_FIFO_EN], fcr_reg[`UIE_FCR_FIFO_EN], 2'b00, ibus.code};
  end

  function automatic logic [7:0] masked(input logic [7:0] old, input logic [7:0] nw,
                                        input logic [7:0] ext, input logic ok);
    masked = ok ? nw : ((old & ext) | (nw & ~ext));
  endfunction

  // Host access decode and register next values.
  always_comb begin
    enh_map = (lcr_reg == `UIE_LCR_ENHANCED);
    dlab    = lcr_reg[`UIE_LCR_DLAB];
    ext_ok  = efr_reg[`UIE_EFR_ENH]; // R16
    ier_next = ier_reg;
    fcr_next = fcr_reg;
    lcr_next = lcr_reg;
    mcr_next = mcr_reg;
    efr_next = efr_reg;
    feature_control_next = feature_control_reg;
    scr_next = scr_reg;
    thr_next = thr_reg;
    rxt_next = rxt_reg;
    txt_next = txt_reg;
    for (int i = 0; i < 4; i++) begin
      chars_next[i] = chars_reg[i];
    end
    rdata_next = rdata_reg;
    oen_next = st2_reg[2] | st2_reg[1];
    rhr_rd_next = 1'b0;
    thr_wr_next = 1'b0;
    isr_rd_next = 1'b0;
    lsr_rd_next = 1'b0;
    rxc_next = 1'b0;
    txc_next = 1'b0;
    if (wr_evt) begin
      if (a == `UIE_OFS_LCR) begin
        lcr_next = wd;
      end else if (enh_map) begin
        if (a == `UIE_OFS_TRG) begin
          if (feature_control_reg[`UIE_FEATURE_CONTROL_TX_SEL]) begin
            txt_next = FILL_W'(wd);
          end else begin
            rxt_next = FILL_W'(wd);
          end
        end else if (a == `UIE_OFS_FEATURE_CONTROL) begin
          feature_control_next = wd;
        end else if (a == `UIE_OFS_EFR) begin
          efr_next = wd;
        end else if (a >= `UIE_OFS_CHAR_BASE) begin
          chars_next[a[1:0]] = wd;
        end
      end else if (dlab) begin
        // Divisor latches live elsewhere; nothing is stored here.
      end else if (a == `UIE_OFS_DATA) begin
        thr_next = wd;
        thr_wr_next = 1'b1;
      end else if (a == `UIE_OFS_IER) begin
        ier_next = masked(ier_reg, wd, `UIE_IER_EXT_MASK, ext_ok); // R15 R16
      end else if (a == `UIE_OFS_ISR_FCR) begin
        // Other bits only take effect while the enable bit is written as one.
        fcr_next[`UIE_FCR_FIFO_EN] = wd[`UIE_FCR_FIFO_EN];
        if (wd[`UIE_FCR_FIFO_EN]) begin
          fcr_next = masked(fcr_reg, wd & 8'hF9, `UIE_FCR_EXT_MASK, ext_ok); // R16
          rxc_next = wd[`UIE_FCR_RX_RST];
          txc_next = wd[`UIE_FCR_TX_RST];
        end
      end else if (a == `UIE_OFS_MCR) begin
        mcr_next = masked(mcr_reg, wd, `UIE_MCR_EXT_MASK, ext_ok); // R16
      end else if (a == `UIE_OFS_SCRATCH) begin
        scr_next = wd;
      end
    end
    if (rd_evt) begin
      if (a == `UIE_OFS_LCR) begin
        rdata_next = lcr_reg;
      end else if (enh_map) begin
        if (a == `UIE_OFS_TRG) begin
          rdata_next = 8'(feature_control_reg[`UIE_FEATURE_CONTROL_TX_SEL] ? tx_fill : rx_fill);
        end else if (a == `UIE_OFS_FEATURE_CONTROL) begin
          rdata_next = feature_control_reg;
        end else if (a == `UIE_OFS_EFR) begin
          rdata_next = efr_reg;
        end else if (a >= `UIE_OFS_CHAR_BASE) begin
          rdata_next = chars_reg[a[1:0]];
        end else begin
          rdata_next = 8'h00;
        end
      end else if (dlab) begin
        if (a == `UIE_OFS_DATA) begin
          rdata_next = REV_CODE;
        end else if (a == `UIE_OFS_IER) begin
          rdata_next = DEV_CODE;
        end else begin
          rdata_next = 8'h00;
        end
      end else if (a == `UIE_OFS_DATA) begin
        rdata_next = rx_data;
        rhr_rd_next = 1'b1;
      end else if (a == `UIE_OFS_IER) begin
        rdata_next = ier_reg;
      end else if (a == `UIE_OFS_ISR_FCR) begin
        rdata_next = isr_val; // R17
        isr_rd_next = 1'b1;
      end else if (a == `UIE_OFS_MCR) begin
        rdata_next = mcr_reg;
      end else if (a == `UIE_OFS_LSR) begin
        rdata_next = line_status;
        lsr_rd_next = 1'b1;
      end else if (a == `UIE_OFS_MSR) begin
        rdata_next = modem_status;
      end else begin
        rdata_next = scr_reg;
      end
    end
    // Hardware sets win over a clear in the same cycle.
    dr_next = rx_push ? 1'b1 : ((rx_fill == '0) ? 1'b0 : dr_reg); // R4
    oe_next = rx_overrun ? 1'b1 : (lsr_rd_next ? 1'b0 : oe_reg); // R6
  end

  // Register update.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ier_reg <= `UIE_RST_BYTE;
      fcr_reg <= `UIE_RST_BYTE;
      lcr_reg <= `UIE_RST_BYTE;
      mcr_reg <= `UIE_RST_BYTE;
      efr_reg <= `UIE_RST_BYTE;
      feature_control_reg <= `UIE_RST_BYTE;
      scr_reg <= `UIE_RST_BYTE;
      thr_reg <= `UIE_RST_BYTE;
      rdata_reg <= `UIE_RST_BYTE;
      for (int i = 0; i < 4; i++) begin
        chars_reg[i] <= `UIE_RST_BYTE;
      end
      rxt_reg <= FILL_W'(`UIE_RST_TRIG);
      txt_reg <= FILL_W'(`UIE_RST_TRIG);
      dr_reg <= 1'b0;
      oe_reg <= 1'b0;
      oen_reg <= 1'b1;
      rhr_rd_reg <= 1'b0;
      thr_wr_reg <= 1'b0;
      isr_rd_reg <= 1'b0;
      lsr_rd_reg <= 1'b0;
      rxc_reg <= 1'b0;
      txc_reg <= 1'b0;
    end else begin
      ier_reg <= ier_next;
      fcr_reg <= fcr_next;
      lcr_reg <= lcr_next;
      mcr_reg <= mcr_next;
      efr_reg <= efr_next;
      feature_control_reg <= feature_control_next;
      scr_reg <= scr_next;
      thr_reg <= thr_next;
      rdata_reg <= rdata_next;
      chars_reg <= chars_next;
      rxt_reg <= rxt_next;
      txt_reg <= txt_next;
      dr_reg <= dr_next;
      oe_reg <= oe_next;
      oen_reg <= oen_next;
      rhr_rd_reg <= rhr_rd_next;
      thr_wr_reg <= thr_wr_next;
      isr_rd_reg <= isr_rd_next;
      lsr_rd_reg <= lsr_rd_next;
      rxc_reg <= rxc_next;
      txc_reg <= txc_next;
    end
  end

  // Feed the interrupt evaluator.
  assign ibus.fifo_en   = fcr_reg[`UIE_FCR_FIFO_EN];
  assign ibus.ier_low   = ier_reg[3:0]; // R1
  assign ibus.rx_fill   = rx_fill;
  assign ibus.rx_trig   = rxt_reg;
  assign ibus.tx_fill   = tx_fill;
  assign ibus.tx_trig   = txt_reg;
  assign ibus.line_err  = |line_status[4:1]; // R13
  assign ibus.modem_evt = modem_evt;
  assign ibus.isr_read  = isr_rd_reg;
  assign ibus.thr_write = thr_wr_reg;

  uie_irq u_irq (
    .clock  (clock),
    .resetn (resetn),
    .bus    (ibus)
  );

  // Outputs straight from flops.
  assign data_out          = rdata_reg;
  assign data_oe_n         = oen_reg;
  assign irq               = ibus.irq;
  assign rhr_read          = rhr_rd_reg;
  assign thr_write         = thr_wr_reg;
  assign thr_data          = thr_reg;
  assign rx_fifo_clr       = rxc_reg;
  assign tx_fifo_clr       = txc_reg;
  assign fifo_enable       = fcr_reg[`UIE_FCR_FIFO_EN];
  assign sleep_enable      = ier_reg[4];
  assign modem_control     = mcr_reg;
  assign enhanced_function = efr_reg;
  assign feature_control   = feature_control_reg;
  assign rx_trigger        = rxt_reg;
  assign tx_trigger        = txt_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  AST_DR_SET: assert property (rx_push |=> dr_reg) // R4
    else $error("Data ready missed a push.");
  AST_DR_CLR: assert property (!rx_push && rx_fill == '0 |=> !dr_reg) // R4
    else $error("Data ready stayed set on empty FIFO.");
  AST_OE_SET: assert property (rx_overrun |=> oe_reg ##1 (oe_reg || $past(lsr_rd_next))) // R6
    else $error("Overrun flag not raised.");
  AST_SLEEP_LOCK: assert property (wr_evt && !ext_ok |=> $stable(ier_reg[7:4])) // R15
    else $error("Extended enable bits written while locked.");
  AST_RD_LSR: assert property (rd_evt && !enh_map && !dlab && a == `UIE_OFS_LSR
    |=> data_out[7:1] == $past(line_status[7:1])) // R8
    else $error("Line status read returned wrong flags.");
endmodule // uie_top
